// ### logic/edge_tally_block.sv
`timescale 1ns/1ps
`include "edge_tally_params.svh"
module edge_tally_block
  import edge_tally_pkg::*;
#(
  parameter int UNITS = `ET_NUM_UNITS,
  parameter int CW    = `ET_CNT_WIDTH
) (
  input  wire logic                   CORE_CLK_IN,  // 20 MHz clock
  input  wire logic                   RST_IN,       // sync reset, high
  input  wire logic                   CE_IN,        // freezes all state
  input  wire logic [UNITS-1:0]       PULSE_CH0_IN, // pulse_input_chan0
  input  wire logic [UNITS-1:0]       PULSE_CH1_IN, // pulse_input_chan1
  input  wire logic [UNITS-1:0]       STEER_CH0_IN, // steer_input_chan0
  input  wire logic [UNITS-1:0]       STEER_CH1_IN, // steer_input_chan1
  input  wire chan_cfg_t [UNITS-1:0]  CFG_CH0_IN,   // channel 0 config
  input  wire chan_cfg_t [UNITS-1:0]  CFG_CH1_IN,   // channel 1 config
  input  wire logic [UNITS-1:0]       CLEAR_IN,     // clear count pulse
  output logic [UNITS-1:0][CW-1:0]    COUNT_OUT     // counter values
);
  // the step arithmetic and the wrap need at least two counter bits
  if (UNITS < 1 || CW < 2 || CW > 32) begin : g_bad_params
    $error("bad edge_tally params");
  end

  // selected action of one channel for the current steer level
  function automatic count_act_t act_of(
    input logic steer, input chan_cfg_t cfg);
    act_of = steer ? cfg.act_hi : cfg.act_lo;
  endfunction

  // apply one channel's action on a counted edge: +1, -1 or 0
  function automatic logic signed [2:0] step_of(
    input logic edge_seen, input logic steer, input chan_cfg_t cfg);
    count_act_t act;
    act = act_of(steer, cfg);
    step_of = 3'sd0;
    if (edge_seen && act == ACT_INC) begin
      step_of = 3'sd1;
    end else if (edge_seen && act == ACT_DEC) begin
      step_of = -3'sd1;
    end
  endfunction

  // chosen edge of a filtered pulse from its previous and current level
  function automatic logic edge_of(
    input logic prev, input logic cur, input logic fall);
    edge_of = fall ? (prev & ~cur) : (~prev & cur);
  endfunction

  // previous filtered levels start at the filters' reset level, so a
  // freshly released unit never sees a false edge
  typedef struct packed {
    logic [UNITS-1:0][CW-1:0] cnt;
    logic [UNITS-1:0]         p0_prev;
    logic [UNITS-1:0]         p1_prev;
  } tally_state_t;

  // the counts and previous pulse levels live in one struct, registered below
  tally_state_t st_q;
  tally_state_t st_d;
  count_act_t       a0 [UNITS]; // chan0 action at current steer
  count_act_t       a1 [UNITS]; // chan1 action at current steer
  logic [UNITS-1:0] p0_f;
  logic [UNITS-1:0] p1_f;
  logic [UNITS-1:0] s0_f;
  logic [UNITS-1:0] s1_f;
  logic [UNITS-1:0] e0;
  logic [UNITS-1:0] e1;

  //////////////////////////////////////////////////////////////////////////
  // one filter per input keeps a noisy steer line from flipping direction
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    glitch_filter u_fp0 (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .ce_in(CE_IN),
      .raw_in(PULSE_CH0_IN[u]), .level_out(p0_f[u]));
    glitch_filter u_fp1 (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .ce_in(CE_IN),
      .raw_in(PULSE_CH1_IN[u]), .level_out(p1_f[u]));
    glitch_filter u_fs0 (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .ce_in(CE_IN),
      .raw_in(STEER_CH0_IN[u]), .level_out(s0_f[u]));
    glitch_filter u_fs1 (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .ce_in(CE_IN),
      .raw_in(STEER_CH1_IN[u]), .level_out(s1_f[u]));
    assign e0[u] = edge_of(st_q.p0_prev[u], p0_f[u], CFG_CH0_IN[u].fall_edge);
    assign e1[u] = edge_of(st_q.p1_prev[u], p1_f[u], CFG_CH1_IN[u].fall_edge);
    assign a0[u] = act_of(s0_f[u], CFG_CH0_IN[u]);
    assign a1[u] = act_of(s1_f[u], CFG_CH1_IN[u]);
  end

  //////////////////////////////////////////////////////////////////////////
  // both channels add into one counter; opposite steps cancel out.
  // pulses beyond the filter bandwidth are lost, the source must keep
  // to the rated rate
  always_comb begin
    logic signed [2:0] sum;
    sum  = 3'sd0;
    st_d = st_q;
    st_d.p0_prev = p0_f;
    st_d.p1_prev = p1_f;
    for (int u = 0; u < UNITS; u++) begin
      sum = step_of(e0[u], s0_f[u], CFG_CH0_IN[u])
          + step_of(e1[u], s1_f[u], CFG_CH1_IN[u]);
      // clear wins over a same-cycle edge; that edge is lost
      if (CLEAR_IN[u]) begin
        st_d.cnt[u] = CW'(`ET_CNT_RESET);
      end else begin
        st_d.cnt[u] = st_q.cnt[u] + CW'(sum);
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      st_q <= '0;
    end else if (CE_IN) begin
      st_q <= st_d;
    end
  end

  // count leaves straight from the flops, never from the adder
  assign COUNT_OUT = st_q.cnt;

  //////////////////////////////////////////////////////////////////////////
  clear_zero_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    CE_IN && CLEAR_IN[0] |=> COUNT_OUT[0] == '0)
    else $error("clear did not zero count");
  inc_one_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    CE_IN && !CLEAR_IN[0] && e0[0] && !e1[0] &&
    ((s0_f[0] ? CFG_CH0_IN[0].act_hi : CFG_CH0_IN[0].act_lo) == ACT_INC)
    |=> COUNT_OUT[0] == $past(COUNT_OUT[0]) + 1'b1)
    else $error("increment missed");
  dec_one_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    CE_IN && !CLEAR_IN[0] && e1[0] && !e0[0] &&
    ((s1_f[0] ? CFG_CH1_IN[0].act_hi : CFG_CH1_IN[0].act_lo) == ACT_DEC)
    |=> COUNT_OUT[0] == $past(COUNT_OUT[0]) - 1'b1)
    else $error("decrement missed");
  idle_hold_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !CLEAR_IN[1] && !e0[1] && !e1[1] |=> $stable(COUNT_OUT[1]))
    else $error("count moved without edge");
  freeze_ce_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !CE_IN |=> $stable(COUNT_OUT))
    else $error("state moved while disabled");
  rise_edge_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !CFG_CH0_IN[2].fall_edge && $rose(p0_f[2]) |-> e0[2])
    else $error("rising edge not seen");
  fall_edge_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    CFG_CH0_IN[2].fall_edge && $rose(p0_f[2]) |-> !e0[2])
    else $error("wrong edge counted");
  filt_lag_a: assert property (
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    CE_IN && PULSE_CH0_IN[3] && !p0_f[3] ##1 CE_IN && PULSE_CH0_IN[3]
    ##1 CE_IN && PULSE_CH0_IN[3] ##1 CE_IN && PULSE_CH0_IN[3]
    ##1 CE_IN |=> p0_f[3])
    else $error("filter lag wrong");

  //////////////////////////////////////////////////////////////////////////
  // the same paths for every unit; a slip in one unit's slice of the
  // state shows up even where a scenario only drives another unit.
  // codes outside the enum also hold, but only the named ones are checked
  for (genvar u = 0; u < UNITS; u++) begin : g_chk
    clear_unit_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CE_IN && CLEAR_IN[u] |=> COUNT_OUT[u] == CW'(`ET_CNT_RESET))
      else $error("clear did not restore count");
    quiet_unit_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CE_IN && !CLEAR_IN[u] && !e0[u] && !e1[u] |=> $stable(COUNT_OUT[u]))
      else $error("count moved in a quiet unit");
    hold_act_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CE_IN && !CLEAR_IN[u] && (!e0[u] || a0[u] == ACT_HOLD) &&
      (!e1[u] || a1[u] == ACT_HOLD) |=> $stable(COUNT_OUT[u]))
      else $error("held action moved the count");
    both_inc_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CE_IN && !CLEAR_IN[u] && e0[u] && e1[u] &&
      a0[u] == ACT_INC && a1[u] == ACT_INC
      |=> COUNT_OUT[u] == $past(COUNT_OUT[u]) + 2'd2)
      else $error("two increments did not add up");
    cancel_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CE_IN && !CLEAR_IN[u] && e0[u] && e1[u] &&
      ((a0[u] == ACT_INC && a1[u] == ACT_DEC) ||
       (a0[u] == ACT_DEC && a1[u] == ACT_INC)) |=> $stable(COUNT_OUT[u]))
      else $error("opposite steps did not cancel");
    dec_ch0_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CE_IN && !CLEAR_IN[u] && e0[u] && !e1[u] && a0[u] == ACT_DEC
      |=> COUNT_OUT[u] == $past(COUNT_OUT[u]) - 1'b1)
      else $error("chan0 decrement missed");
    inc_ch1_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CE_IN && !CLEAR_IN[u] && e1[u] && !e0[u] && a1[u] == ACT_INC
      |=> COUNT_OUT[u] == $past(COUNT_OUT[u]) + 1'b1)
      else $error("chan1 increment missed");
    rise_ch0_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !CFG_CH0_IN[u].fall_edge && $rose(p0_f[u]) |-> e0[u])
      else $error("chan0 rising edge not seen");
    fall_ch0_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CFG_CH0_IN[u].fall_edge && $fell(p0_f[u]) |-> e0[u])
      else $error("chan0 falling edge not seen");
    rise_ch1_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !CFG_CH1_IN[u].fall_edge && $rose(p1_f[u]) |-> e1[u])
      else $error("chan1 rising edge not seen");
    fall_ch1_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (RST_IN)
      CFG_CH1_IN[u].fall_edge && $fell(p1_f[u]) |-> e1[u])
      else $error("chan1 falling edge not seen");
  end

  // main scenarios: counting up, wrapping down, clear racing an edge,
  // both channels at once, and a held pulse while frozen
  up_c:    cover property (@(posedge CORE_CLK_IN) COUNT_OUT[0] == 16'h0003);
  wrap_c:  cover property (@(posedge CORE_CLK_IN) COUNT_OUT[0] == 16'hFFFF);
  clear_c: cover property (@(posedge CORE_CLK_IN) CLEAR_IN[0] && e0[0]);
  both_c:  cover property (@(posedge CORE_CLK_IN) e0[0] && e1[0]);
  freeze_c: cover property (@(posedge CORE_CLK_IN) !CE_IN && PULSE_CH0_IN[0]);
endmodule // edge_tally_block

// ### inc/edge_tally_params.svh
// Functional notes
// - four independent units, own configuration and count
// - counter is sixteen bits, range to 65535
// - two channels update one shared counter
// - each channel has pulse and steer inputs
// - every pulse and steer input filtered separately
// - per channel select rising or falling edge
// - steer high/low each pick inc, dec, hold
`ifndef EDGE_TALLY_PARAMS_SVH
`define EDGE_TALLY_PARAMS_SVH
`define ET_NUM_UNITS    4
`define ET_CNT_WIDTH    16
`define ET_CNT_RESET    16'h0000
`define ET_FILT_LEN     4
`define ET_MAX_PULSE_MHZ 40
`define ET_CLK_MHZ      20
`endif

// ### inc/edge_tally_pkg.sv
package edge_tally_pkg;
  // action taken on a counted edge
  typedef enum logic [1:0] {
    ACT_HOLD,
    ACT_INC,
    ACT_DEC
  } count_act_t;

  // per-channel configuration
  typedef struct packed {
    logic       fall_edge;   // 1: count falling edges
    count_act_t act_hi;      // action while steer is high
    count_act_t act_lo;      // action while steer is low
  } chan_cfg_t;

  // filter state for one input
  typedef struct packed {
    logic [3:0] hist;
    logic       level;
  } filt_state_t;
endpackage

// ### logic/glitch_filter.sv
`timescale 1ns/1ps
`include "edge_tally_params.svh"
module glitch_filter
  import edge_tally_pkg::*;
#(
  parameter int LEN = `ET_FILT_LEN
) (
  input  wire logic clk_in,   // core clock
  input  wire logic rst_in,   // sync reset
  input  wire logic ce_in,    // clock enable
  input  wire logic raw_in,   // unfiltered input
  output logic      level_out // filtered level
);
  // the history vector in the package is four samples wide
  if (LEN != 4) begin : g_bad_len
    $error("glitch_filter supports LEN of 4 only");
  end

  filt_state_t s_q;
  filt_state_t s_d;

  // level follows only once the input stood still for LEN samples,
  // so shorter spikes never reach the counter
  always_comb begin
    s_d = s_q;
    s_d.hist = {s_q.hist[2:0], raw_in};
    if (s_q.hist == 4'hF) begin
      s_d.level = 1'b1;
    end else if (s_q.hist == 4'h0) begin
      s_d.level = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;

  stable_high_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && s_q.hist == 4'hF |=> s_q.level)
    else $error("filter did not rise after stable high");
  stable_low_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && s_q.hist == 4'h0 |=> !s_q.level)
    else $error("filter did not fall after stable low");
  // a history that is not all ones must never lift a low level
  spike_block_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !s_q.level && s_q.hist != 4'hF |=> !s_q.level)
    else $error("short spike reached the level");
endmodule // glitch_filter

// ### sim/pulse_source.sv
`timescale 1ns/1ps
// far-side pulse and steer source; levels are held whole cycles only
module pulse_source (
  input  wire logic clk_in,      // core clock
  output logic [3:0] pulse0_out, // chan0 pulses
  output logic [3:0] pulse1_out, // chan1 pulses
  output logic [3:0] steer0_out, // chan0 steer
  output logic [3:0] steer1_out  // chan1 steer
);
  initial {pulse0_out, pulse1_out, steer0_out, steer1_out} = '0;
  // one level change, held len cycles; len 6 keeps the rate legal
  task automatic flip(input logic [3:0] m0, m1, input int len);
    @(posedge clk_in);
    pulse0_out <= pulse0_out ^ m0;
    pulse1_out <= pulse1_out ^ m1;
    repeat (len - 1) @(posedge clk_in);
  endtask
  // steer settles past the filter before any pulse edge follows
  task automatic steer(input logic [3:0] s0, s1);
    @(posedge clk_in);
    steer0_out <= s0;
    steer1_out <= s1;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // pulse_source

// ### sim/edge_tally_block_tb_top.sv
`timescale 1ns/1ps
module edge_tally_block_tb_top
  import edge_tally_pkg::*;
;
  logic             clk, rst, st, ce;
  logic       [3:0] p0, p1, s0, s1, clr;
  chan_cfg_t  [3:0] cfg0, cfg1;
  logic      [63:0] cnt, exp_v, seen;
  logic      [63:0] expq[$];
  int               failures, samples_checked, cycles;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  edge_tally_block u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .PULSE_CH0_IN(p0), .PULSE_CH1_IN(p1), .STEER_CH0_IN(s0),
    .STEER_CH1_IN(s1), .CFG_CH0_IN(cfg0), .CFG_CH1_IN(cfg1),
    .CLEAR_IN(clr), .COUNT_OUT(cnt));
  pulse_source u_src (.clk_in(clk), .pulse0_out(p0), .pulse1_out(p1),
    .steer0_out(s0), .steer1_out(s1));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] e, g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // note lands before the edge; filter delay keeps it ahead of the change
  task automatic note(input logic [3:0] m, input logic [15:0] d);
    for (int u = 0; u < 4; u++)
      if (m[u]) exp_v[16*u +: 16] = exp_v[16*u +: 16] + d;
    if (d != 16'h0000) expq.push_back(exp_v);
  endtask
  function automatic logic [15:0] dlt(input int a);
    return (a == 1) ? 16'h0001 : (a == 2) ? 16'hffff : 16'h0000;
  endfunction
  task automatic setcfg(input chan_cfg_t [3:0] n0, n1);
    @(posedge clk);
    cfg0 <= n0;
    cfg1 <= n1;
  endtask
  // one full pulse; only the selected edge may move the count
  task automatic pulse(input int u, c, a, f);
    chan_cfg_t [3:0] n0, n1;
    chan_cfg_t       k;
    logic      [3:0] m, sm;
    n0 = '0;
    n1 = '0;
    m = 4'(1 << u);
    st = 1'($urandom);
    sm = st ? m : 4'h0;
    k.fall_edge = 1'(f);
    k.act_hi = count_act_t'(st ? a : $urandom % 3);
    k.act_lo = count_act_t'(st ? $urandom % 3 : a);
    if (c == 1) n1[u] = k;
    else n0[u] = k;
    setcfg(n0, n1);
    u_src.steer(c ? 4'h0 : sm, c ? sm : 4'h0);
    if (f == 0) note(m, dlt(a));
    u_src.flip(c ? 4'h0 : m, c ? m : 4'h0, 6);
    if (f == 1) note(m, dlt(a));
    u_src.flip(c ? 4'h0 : m, c ? m : 4'h0, 6);
  endtask
  // both channels of every unit edge together; contributions add up
  task automatic pair(input int a0, a1);
    setcfg({4{chan_cfg_t'({1'b0, count_act_t'(a0), count_act_t'(a0)})}},
           {4{chan_cfg_t'({1'b0, count_act_t'(a1), count_act_t'(a1)})}});
    note(4'hf, dlt(a0) + dlt(a1));
    u_src.flip(4'hf, 4'hf, 6);
    u_src.flip(4'hf, 4'hf, 6);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // each count change must match the oldest note; a stray one fails
  always @(negedge clk) begin
    if (rst) seen = 64'h0;
    else if (cnt !== seen) begin
      check("count", expq.size() ? expq.pop_front() : seen, cnt);
      seen = cnt;
    end
  end
  // hang guard, roughly three times the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(64227));
    rst = 1'b1;
    cfg0 = '0;
    cfg1 = '0;
    clr = 4'h0;
    ce = 1'b1;
    exp_v = 64'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    check("reset count", 64'h0, cnt);
    for (int u = 0; u < 4; u++)
      for (int c = 0; c < 2; c++)
        for (int a = 0; a < 3; a++)
          for (int f = 0; f < 2; f++) pulse(u, c, a, f);
    pair(1, 2);
    pair(1, 1);
    // a two-cycle spike must never reach the count
    u_src.flip(4'hf, 4'hf, 2);
    u_src.flip(4'hf, 4'hf, 6);
    // a pulse held while frozen counts only once enable is back
    @(posedge clk);
    ce <= 1'b0;
    u_src.flip(4'h1, 4'h0, 10);
    @(posedge clk);
    ce <= 1'b1;
    note(4'h1, 16'h0001);
    repeat (8) @(posedge clk);
    u_src.flip(4'h1, 4'h0, 6);
    @(posedge clk);
    clr <= 4'h5;
    exp_v[15:0] = 16'h0000;
    exp_v[47:32] = 16'h0000;
    expq.push_back(exp_v);
    @(posedge clk);
    clr <= 4'h0;
    pulse(0, 1, 2, 1);
    repeat (10) @(posedge clk);
    check("pending notes", 64'h0, 64'(expq.size()));
    finish_test();
  end
endmodule // edge_tally_block_tb_top
